/* hdl/vpd_dispatch.v */
`timescale 1ns/10ps
`include "vpd_defs.vh"
module vpd_dispatch (
    // Clock and reset
    input wire sys_clk_in,
    input wire rst_in,
    // Program memory fetch
    output wire fetch_req_out,
    output wire [31:0] fetch_addr_out,
    input wire fetch_valid_in,
    input wire [255:0] fetch_data_in,
    // Issue to the eight units
    output wire [7:0] unit_valid_out,
    output wire [255:0] unit_instr_out,
    output wire [255:0] unit_operand_out,
    output wire packet_issue_out,
    output wire unit_conflict_out,
    output wire illegal_op_out,
    output wire cross_conflict_out,
    // Unit result write-back
    input wire [7:0] unit_wr_en_in,
    input wire [7:0] unit_wr_cross_in,
    input wire [31:0] unit_wr_reg_in,
    input wire [255:0] unit_wr_data_in,
    // Data memory, one channel per side
    output wire [1:0] mem_req_out,
    output wire [1:0] mem_we_out,
    output wire [63:0] mem_addr_out,
    output wire [3:0] mem_size_out,
    output wire [127:0] mem_wdata_out,
    output wire [13:0] mem_tag_out,
    // Load returns, one channel per side
    input wire [1:0] ld_ret_valid_in,
    input wire [13:0] ld_ret_tag_in,
    input wire [127:0] ld_ret_data_in
);

// ************************************************
// State
// ************************************************
localparam ST_FETCH = `VPD_ST_FETCH;
localparam ST_ISSUE = `VPD_ST_ISSUE;

reg [1:0] state_q;
reg [1:0] state_d;
reg [2:0] pos_q;
reg [2:0] pos_d;
reg [31:0] pc_q;
reg [255:0] pkt_q;
reg [31:0] rf_q [0:31];
reg [7:0] unit_valid_q;
reg [255:0] unit_instr_q;
reg [255:0] unit_op_q;
reg packet_q;
reg conf_q;
reg ill_q;
reg xconf_q;
reg [7:0] wr_ok;
reg [1:0] xwr_used;
reg xwr_conf;
integer k;

// ************************************************
// Packet split and routing
// ************************************************
reg [7:0] in_pkt;
reg [7:0] claimed;
reg [7:0] issue_v;
reg [255:0] issue_i;
reg [255:0] issue_op;
reg [2:0] last_slot;
reg link;
reg [1:0] xrd_used;
reg conf_d;
reg ill_d;
reg xconf_d;
reg [31:0] ins;
reg [2:0] u;
reg [2:0] cl;
reg cond_ok;
reg bad;
integer j;

always @* begin
    in_pkt = 8'h00;
    claimed = 8'h00;
    issue_v = 8'h00;
    issue_i = {256{1'b0}};
    issue_op = {256{1'b0}};
    last_slot = 3'h7;
    link = 1'b1;
    xrd_used = 2'h0;
    conf_d = 1'b0;
    ill_d = 1'b0;
    xconf_d = 1'b0;
    ins = 32'h00000000;
    u = 3'h0;
    cl = 3'h0;
    cond_ok = 1'b0;
    bad = 1'b0;
    for (j = 0; j < 8; j = j + 1) begin
        ins = pkt_q[j*32 +: 32];
        if (state_q == ST_ISSUE && j >= pos_q && link) begin
            in_pkt[j] = 1'b1;
            if (!ins[`VPD_CHAIN]) begin
                link = 1'b0;
                last_slot = j[2:0];
            end
        end
        if (in_pkt[j]) begin
            // bit 2 of unit is the side
            u = ins[`VPD_UNIT];
            cl = ins[`VPD_CLASS];
            cond_ok = (ins[`VPD_COND] == 3'h0) ||
                (rf_q[{2'h0, ins[`VPD_COND]}] != 32'h00000000);
            bad = ((cl == `VPD_CL_FALU || cl == `VPD_CL_FMUL) &&
                   u[1:0] == `VPD_K_SHIFT) ||
                  ((cl == `VPD_CL_MUL || cl == `VPD_CL_FMUL) &&
                   u[1:0] != `VPD_K_MUL) ||
                  ((cl == `VPD_CL_LOAD || cl == `VPD_CL_STORE) &&
                   u[1:0] != `VPD_K_ADDR) ||
                  (cl == `VPD_CL_BR && u[1:0] != `VPD_K_LOGIC &&
                   u[1:0] != `VPD_K_SHIFT);
            if (cl == `VPD_CL_NOP) begin
                bad = 1'b0;
            end else if (bad) begin
                ill_d = 1'b1;
            end else if (claimed[u]) begin
                conf_d = 1'b1;
            end else if (ins[`VPD_CROSS] && u[1:0] != `VPD_K_ADDR &&
                         xrd_used[u[2]]) begin
                xconf_d = 1'b1;
            end else begin
                claimed[u] = 1'b1;
                if (ins[`VPD_CROSS] && u[1:0] != `VPD_K_ADDR)
                    xrd_used[u[2]] = 1'b1;
                if (cond_ok) begin
                    issue_v[u] = 1'b1;
                    issue_i[u*32 +: 32] = ins;
                    issue_op[u*32 +: 32] =
                        rf_q[{u[2] ^ ins[`VPD_CROSS], ins[`VPD_DREG]}];
                end
            end
        end
    end
end

// ************************************************
// Fetch and dispatch sequencing
// ************************************************
always @* begin
    state_d = state_q;
    pos_d = pos_q;
    case (state_q)
        ST_FETCH: begin
            if (fetch_valid_in) begin
                state_d = ST_ISSUE;
                pos_d = 3'h0;
            end
        end
        ST_ISSUE: begin
            // slot 7 always closes the packet
            if (last_slot == 3'h7)
                state_d = ST_FETCH;
            else
                pos_d = last_slot + 3'h1;
        end
        default: begin
            state_d = ST_FETCH;
        end
    endcase
end

always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
        state_q <= ST_FETCH;
        pos_q <= 3'h0;
        pc_q <= `VPD_RESET_PC;
        pkt_q <= {256{1'b0}};
        unit_valid_q <= 8'h00;
        unit_instr_q <= {256{1'b0}};
        unit_op_q <= {256{1'b0}};
        packet_q <= 1'b0;
        conf_q <= 1'b0;
        ill_q <= 1'b0;
        xconf_q <= 1'b0;
    end else begin
        state_q <= state_d;
        pos_q <= pos_d;
        if (state_q == ST_FETCH && fetch_valid_in) begin
            pkt_q <= fetch_data_in;
            pc_q <= pc_q + `VPD_FP_STEP;
        end
        unit_valid_q <= issue_v;
        unit_instr_q <= issue_i;
        unit_op_q <= issue_op;
        packet_q <= (state_q == ST_ISSUE);
        conf_q <= conf_d;
        ill_q <= ill_d;
        xconf_q <= xconf_d | xwr_conf;
    end
end

// ************************************************
// Write-back ports
// ************************************************
always @* begin
    wr_ok = 8'h00;
    xwr_used = 2'h0;
    xwr_conf = 1'b0;
    for (k = 0; k < 8; k = k + 1) begin
        if (unit_wr_en_in[k]) begin
            if (unit_wr_cross_in[k] && xwr_used[k/4]) begin
                xwr_conf = 1'b1;
            end else begin
                wr_ok[k] = 1'b1;
                if (unit_wr_cross_in[k])
                    xwr_used[k/4] = 1'b1;
            end
        end
    end
end

function [31:0] vpd_ext;
    input [1:0] size;
    input [31:0] data;
    begin
        case (size)
            `VPD_SZ_BYTE: vpd_ext = {24'h000000, data[7:0]};
            `VPD_SZ_HALF: vpd_ext = {16'h0000, data[15:0]};
            default: vpd_ext = data;
        endcase
    end
endfunction

integer m;

// two 16-entry files in one array
always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
        for (m = 0; m < 32; m = m + 1)
            rf_q[m] <= 32'h00000000;
    end else begin
        // Later ports win; load returns last
        for (m = 0; m < 8; m = m + 1) begin
            if (wr_ok[m]) begin
                rf_q[{(m >= 4) ^ unit_wr_cross_in[m],
                    unit_wr_reg_in[m*4 +: 4]}] <=
                    unit_wr_data_in[m*32 +: 32];
            end
        end
        for (m = 0; m < 2; m = m + 1) begin
            if (ld_ret_valid_in[m]) begin
                if (ld_ret_tag_in[m*7+5 +: 2] == `VPD_SZ_DWORD) begin
                    rf_q[{ld_ret_tag_in[m*7+1 +: 4], 1'b0}] <=
                        ld_ret_data_in[m*64 +: 32];
                    rf_q[{ld_ret_tag_in[m*7+1 +: 4], 1'b1}] <=
                        ld_ret_data_in[m*64+32 +: 32];
                end else begin
                    rf_q[ld_ret_tag_in[m*7 +: 5]] <=
                        vpd_ext(ld_ret_tag_in[m*7+5 +: 2],
                        ld_ret_data_in[m*64 +: 32]);
                end
            end
        end
    end
end

// ************************************************
// Address units
// ************************************************
genvar s;
generate
    for (s = 0; s < 2; s = s + 1) begin : g_side
        wire [31:0] ai = issue_i[(s*4+3)*32 +: 32];
        wire lng = ai[`VPD_LONG];
        wire [3:0] breg = lng ? `VPD_BREG_LONG : ai[`VPD_BREG];
        wire [3:0] dreg = lng ? {2'h0, ai[`VPD_DREG_L]} : ai[`VPD_DREG];
        // data side may differ from base side
        wire dside = (s == 1) ^ ai[`VPD_CROSS];
        wire [31:0] base = rf_q[{s == 1, breg}];
        wire [31:0] ofs = lng ? {17'h00000, ai[`VPD_OFS15]} :
                                {27'h0000000, ai[`VPD_OFS5]};
        wire [31:0] step = ofs << ai[`VPD_SIZE];
        wire [31:0] lin = base + step;
        wire [31:0] addr = ai[`VPD_CIRC] ?
            ((base & ~`VPD_CIRC_MASK) | (lin & `VPD_CIRC_MASK)) : lin;
        wire [31:0] lo = rf_q[{dside, dreg[3:1],
            dreg[0] & (ai[`VPD_SIZE] != `VPD_SZ_DWORD)}];
        wire [31:0] hi = rf_q[{dside, dreg[3:1], 1'b1}];
        wire ld = ai[`VPD_CLASS] == `VPD_CL_LOAD;
        wire st = ai[`VPD_CLASS] == `VPD_CL_STORE;
        reg req_q;
        reg we_q;
        reg [31:0] addr_q;
        reg [1:0] size_q;
        reg [63:0] wdata_q;
        reg [6:0] tag_q;
        always @(posedge sys_clk_in or posedge rst_in) begin
            if (rst_in) begin
                req_q <= 1'b0;
                we_q <= 1'b0;
                addr_q <= 32'h00000000;
                size_q <= 2'h0;
                wdata_q <= 64'h0000000000000000;
                tag_q <= 7'h00;
            end else begin
                req_q <= issue_v[s*4+3] & (ld | st);
                we_q <= issue_v[s*4+3] & st;
                addr_q <= addr;
                size_q <= ai[`VPD_SIZE];
                wdata_q <= (ai[`VPD_SIZE] == `VPD_SZ_DWORD) ?
                    {hi, lo} : {32'h00000000, lo};
                tag_q <= {ai[`VPD_SIZE], dside, dreg};
            end
        end
        assign mem_req_out[s] = req_q;
        assign mem_we_out[s] = we_q;
        assign mem_addr_out[s*32 +: 32] = addr_q;
        assign mem_size_out[s*2 +: 2] = size_q;
        assign mem_wdata_out[s*64 +: 64] = wdata_q;
        assign mem_tag_out[s*7 +: 7] = tag_q;
    end
endgenerate

// ************************************************
// Outputs
// ************************************************
assign fetch_req_out = (state_q == ST_FETCH);
assign fetch_addr_out = pc_q;
assign unit_valid_out = unit_valid_q;
assign unit_instr_out = unit_instr_q;
assign unit_operand_out = unit_op_q;
assign packet_issue_out = packet_q;
assign unit_conflict_out = conf_q;
assign illegal_op_out = ill_q;
assign cross_conflict_out = xconf_q;

endmodule

/* inc/vpd_defs.vh */
`ifndef VPD_DEFS_VH
`define VPD_DEFS_VH
// How it works
// - Program memory is read as 256-bit fetch packets of eight 32-bit slots.
// - Instruction LSB of 1 chains the next slot into the same packet.
// - Instruction LSB of 0 ends the packet; the next slot issues later.
// - An execute packet holds at most eight instructions issued together.
// - Any split of a fetch packet into one to eight packets is accepted.
// - At most one execute packet is dispatched per clock cycle; none while fetching.
// - The next fetch waits until all packets of this one are dispatched.
// - Units without an instruction this cycle stay idle.
// - Two register files, A and B, each sixteen 32-bit registers.
// - Side A holds logic, shift, multiply, address units 1; side B units 2.
// - A register file serves all four same-side units in one cycle.
// - One cross-side read and one cross-side write per side per cycle.
// - Logic, multiply and address units do floating point; shift units don't.
// - Double-word load moves 64 bits per side, 128 bits per cycle total.
// - An address from one side may load or store the other side's file.
// - Indirect addressing is linear or circular with 5- or 15-bit offset.
// - Every instruction is conditional on a register unless always true.
// - Only multiply units multiply; logic and shift units do ALU and branch.
// - Loads and stores support byte, half-word and word sizes.

// ************************************************
// Fetch
// ************************************************
`define VPD_FP_STEP 32'h00000020
`define VPD_RESET_PC 32'h00000000

// ************************************************
// Instruction fields
// ************************************************
`define VPD_CHAIN 0
`define VPD_UNIT 3:1
`define VPD_CLASS 6:4
`define VPD_SIZE 8:7
`define VPD_LONG 9
`define VPD_CIRC 10
`define VPD_CROSS 11
`define VPD_DREG 15:12
`define VPD_DREG_L 13:12
`define VPD_BREG 19:16
`define VPD_OFS5 24:20
`define VPD_OFS15 28:14
`define VPD_COND 31:29
`define VPD_BREG_LONG 4'hF

// ************************************************
// Encodings
// ************************************************
`define VPD_CL_ALU 3'h0
`define VPD_CL_BR 3'h1
`define VPD_CL_MUL 3'h2
`define VPD_CL_LOAD 3'h3
`define VPD_CL_FALU 3'h4
`define VPD_CL_FMUL 3'h5
`define VPD_CL_STORE 3'h6
`define VPD_CL_NOP 3'h7
`define VPD_K_LOGIC 2'h0
`define VPD_K_SHIFT 2'h1
`define VPD_K_MUL 2'h2
`define VPD_K_ADDR 2'h3
`define VPD_SZ_BYTE 2'h0
`define VPD_SZ_HALF 2'h1
`define VPD_SZ_WORD 2'h2
`define VPD_SZ_DWORD 2'h3
`define VPD_CIRC_MASK 32'h000000FF
`define VPD_ST_FETCH 2'h1
`define VPD_ST_ISSUE 2'h2
`endif

/* verification/vpd_dispatch_monitor.sv */
`timescale 1ns/10ps
// ************************************************
// Dispatch checker
// ************************************************
module vpd_dispatch_monitor (
    input wire sys_clk_in,
    input wire rst_in,
    input wire fetch_req_out,
    input wire [31:0] fetch_addr_out,
    input wire fetch_valid_in,
    input wire [7:0] unit_valid_out,
    input wire [255:0] unit_instr_out,
    input wire packet_issue_out,
    input wire unit_conflict_out
);
    wire take = fetch_req_out && fetch_valid_in;
    reg [1:0] take_q;
    reg [3:0] cnt_q;
    reg bad_route;
    reg bad_idle;
    reg [3:0] ends;
    integer u;
    always @* begin
        bad_route = 1'b0;
        bad_idle = 1'b0;
        ends = 4'h0;
        for (u = 0; u < 8; u = u + 1) begin
            if (unit_valid_out[u]) begin
                bad_route = bad_route | (unit_instr_out[32*u+1 +: 3] != u);
                ends = ends + {3'h0, ~unit_instr_out[32*u]};
            end else begin
                bad_idle = bad_idle | (unit_instr_out[32*u +: 32] != 32'h0);
            end
        end
    end
    // Counts packets per fetch, restarted when the first one lands
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            take_q <= 2'h0;
            cnt_q <= 4'h0;
        end else begin
            take_q <= {take_q[0], take};
            if (take_q[1])
                cnt_q <= {3'h0, packet_issue_out};
            else
                cnt_q <= cnt_q + {3'h0, packet_issue_out};
        end
    end
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    take_hold_a: assert property (take |=> !fetch_req_out)
        else $error("fetch request stayed up after take");
    addr_step_a: assert property (
        take |=> fetch_addr_out == $past(fetch_addr_out) + 32'h20)
        else $error("fetch address did not step by one packet");
    addr_still_a: assert property (!take |=> $stable(fetch_addr_out))
        else $error("fetch address moved without a take");
    first_issue_a: assert property (take |-> ##2 packet_issue_out)
        else $error("first packet not issued two cycles after take");
    packet_max_a: assert property (cnt_q <= 4'h8)
        else $error("more than eight packets from one fetch");
    unit_route_a: assert property (!bad_route)
        else $error("instruction issued to a unit it does not name");
    idle_zero_a: assert property (!bad_idle)
        else $error("idle unit shows an instruction");
    one_end_a: assert property (ends <= 4'h1)
        else $error("packet holds two chain breaks");
    valid_issue_a: assert property (|unit_valid_out |-> packet_issue_out)
        else $error("unit issued outside a packet slot");
    cover property (take);
    cover property (unit_valid_out == 8'hFF);
    cover property (unit_conflict_out);
endmodule
bind vpd_dispatch vpd_dispatch_monitor mon_u (.sys_clk_in, .rst_in,
    .fetch_req_out, .fetch_addr_out, .fetch_valid_in, .unit_valid_out,
    .unit_instr_out, .packet_issue_out, .unit_conflict_out);

/* verification/vpd_dispatch_test.sv */
`timescale 1ns/10ps
module vpd_dispatch_test;
    reg sys_clk_in = 1'b0;
    reg rst_in = 1'b1;
    reg [7:0] wr_en = 8'h00;
    reg [7:0] wr_x = 8'h00;
    reg [31:0] wr_reg = 32'h0;
    reg [255:0] wr_data = 256'h0;
    reg [1:0] ld_v = 2'h0;
    reg [13:0] ld_tag = 14'h0;
    reg [127:0] ld_data = 128'h0;
    reg [3:0] lag = 4'h0;
    reg [3:0] lim = 4'h0;
    wire req, fv, issue, conf, ill;
    wire [31:0] addr;
    wire [255:0] fd, ops;
    wire [7:0] uv;
    wire xconf;
    wire [1:0] mreq, mwe;
    wire [3:0] msize;
    wire [63:0] maddr;
    wire [127:0] mwdata;
    wire [13:0] mtag;
    reg [3:0] last_mreq = 4'h0, last_msize = 4'h0;
    reg [63:0] last_maddr = 64'h0;
    reg [127:0] last_mwdata = 128'h0;
    reg [13:0] last_mtag = 14'h0;
    reg [7:0] seen [$];
    integer stamp [$];
    integer cyc = 0, failures = 0, checks_done = 0, n_conf = 0, n_ill = 0, j;
    integer n_x = 0;
    reg [255:0] last_ops;
    vpd_prog_mem mem_u (.clk_in(sys_clk_in), .rst_in(rst_in), .req_in(req),
        .addr_in(addr), .lag_in(lag), .limit_in(lim), .valid_out(fv),
        .data_out(fd));
    vpd_dispatch dut_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .fetch_req_out(req), .fetch_addr_out(addr), .fetch_valid_in(fv),
        .fetch_data_in(fd), .unit_valid_out(uv), .unit_instr_out(),
        .unit_operand_out(ops), .packet_issue_out(issue),
        .unit_conflict_out(conf), .illegal_op_out(ill),
        .cross_conflict_out(xconf), .unit_wr_en_in(wr_en),
        .unit_wr_cross_in(wr_x), .unit_wr_reg_in(wr_reg),
        .unit_wr_data_in(wr_data), .mem_req_out(mreq), .mem_we_out(mwe),
        .mem_addr_out(maddr), .mem_size_out(msize), .mem_wdata_out(mwdata),
        .mem_tag_out(mtag), .ld_ret_valid_in(ld_v), .ld_ret_tag_in(ld_tag),
        .ld_ret_data_in(ld_data));
    initial forever #12.5 sys_clk_in = ~sys_clk_in;
    // ************************************************
    // Issue log and hang guard
    // ************************************************
    // Sampled mid-cycle, never on the edge that launches the outputs
    always @(negedge sys_clk_in) begin
        cyc <= cyc + 1;
        if (issue) begin
            seen.push_back(uv);
            stamp.push_back(cyc);
            if (uv != 8'h00)
                last_ops = ops;
        end
        if (mreq != 2'h0) begin
            last_mreq = {mwe, mreq};
            last_msize = msize;
            last_maddr = maddr;
            last_mwdata = mwdata;
            last_mtag = mtag;
        end
        n_conf = n_conf + conf;
        n_ill = n_ill + ill;
        n_x = n_x + xconf;
        if (cyc > 3000) begin
            failures = failures + 1;
            report_and_stop;
        end
    end
    function [31:0] ins(input c, input [2:0] un, input [2:0] cl,
        input [3:0] dr, input x);
        ins = {16'h0, dr, x, 4'h0, cl, un, c};
    endfunction
    task check_mask(input [7:0] got, input [7:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("wrong value at %0t: mask %h not %h", $time, got, exp);
            end
        end
    endtask
    task check_word(input [31:0] got, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("wrong value at %0t: word %h not %h", $time, got, exp);
            end
        end
    endtask
    task run_start(input [3:0] lg, input [3:0] lm);
        begin
            @(negedge sys_clk_in);
            rst_in = 1'b1;
            lag = lg;
            lim = lm;
            @(negedge sys_clk_in);
            rst_in = 1'b0;
            seen.delete();
            stamp.delete();
            n_conf = 0;
            n_ill = 0;
            n_x = 0;
        end
    endtask
    task wait_for(input integer n);
        integer k;
        begin
            k = 0;
            while (seen.size() < n && k < 100) begin
                @(negedge sys_clk_in);
                k = k + 1;
            end
            repeat (3) @(negedge sys_clk_in);
            check_word(seen.size(), n);
        end
    endtask
    // ************************************************
    // Scenarios
    // ************************************************
    task t_full;
        begin
            for (j = 0; j < 8; j = j + 1)
                mem_u.prog[0][32*j +: 32] = ins(j < 7, j, 3'h0, 4'h0, 1'b0);
            run_start(4'h0, 4'h1);
            wait_for(1);
            check_mask(seen[0], 8'hFF);
        end
    endtask
    task t_slow;
        begin
            for (j = 0; j < 8; j = j + 1)
                mem_u.prog[1][32*j +: 32] = ins(1'b0, j, 3'h0, 4'h0, 1'b0);
            run_start(4'h3, 4'h2);
            wait_for(9);
            check_mask(seen[0], 8'hFF);
            for (j = 0; j < 8; j = j + 1)
                check_mask(seen[j+1], 8'h01 << j);
            check_word(stamp[8] - stamp[1], 32'h7);
            check_word(addr, 32'h40);
        end
    endtask
    task t_drop;
        begin
            mem_u.prog[0][31:0] = ins(1'b1, 3'h0, 3'h0, 4'h0, 1'b0);
            mem_u.prog[0][63:32] = ins(1'b0, 3'h0, 3'h0, 4'h0, 1'b0);
            mem_u.prog[0][95:64] = ins(1'b0, 3'h1, 3'h4, 4'h0, 1'b0);
            for (j = 3; j < 8; j = j + 1)
                mem_u.prog[0][32*j +: 32] = ins(j < 7, 3'h0, 3'h7, 4'h0, 1'b0);
            run_start(4'h1, 4'h1);
            wait_for(3);
            check_mask(seen[0], 8'h01);
            check_mask(seen[1], 8'h00);
            check_mask(seen[2], 8'h00);
            check_word(n_conf, 32'h1);
            check_word(n_ill, 32'h1);
        end
    endtask
    task t_regs;
        begin
            mem_u.prog[0][31:0] = ins(1'b1, 3'h0, 3'h0, 4'h3, 1'b0);
            mem_u.prog[0][63:32] = ins(1'b1, 3'h4, 3'h0, 4'h3, 1'b0);
            mem_u.prog[0][95:64] = ins(1'b1, 3'h1, 3'h0, 4'h3, 1'b1);
            mem_u.prog[0][127:96] = ins(1'b0, 3'h2, 3'h2, 4'h6, 1'b0);
            for (j = 4; j < 8; j = j + 1)
                mem_u.prog[0][32*j +: 32] = ins(j < 7, 3'h0, 3'h7, 4'h0, 1'b0);
            run_start(4'h0, 4'h0);
            wr_en = 8'h11;
            wr_reg = 32'h00030003;
            wr_data[31:0] = 32'hA5A50001;
            wr_data[159:128] = 32'h5A5A0002;
            ld_v = 2'h1;
            ld_tag = 14'h0026;
            ld_data = {96'h0, 32'hC3C30003};
            @(negedge sys_clk_in);
            wr_en = 8'h00;
            ld_v = 2'h0;
            lim = 4'h1;
            wait_for(2);
            check_mask(seen[0], 8'h17);
            check_word(last_ops[31:0], 32'hA5A50001);
            check_word(last_ops[159:128], 32'h5A5A0002);
            check_word(last_ops[63:32], 32'h5A5A0002);
            check_word(last_ops[95:64], 32'h00000003);
        end
    endtask
    task t_mem;
        begin
            // Word load into side B from an A address, word store from B
            mem_u.prog[0][31:0] = ins(1'b1, 3'h3, 3'h3, 4'h5, 1'b1) |
                32'h00300100;
            mem_u.prog[0][63:32] = ins(1'b1, 3'h7, 3'h6, 4'h3, 1'b0) |
                32'h00000100;
            mem_u.prog[0][95:64] = ins(1'b1, 3'h1, 3'h0, 4'h0, 1'b1);
            mem_u.prog[0][127:96] = ins(1'b0, 3'h0, 3'h0, 4'h0, 1'b1);
            for (j = 4; j < 8; j = j + 1)
                mem_u.prog[0][32*j +: 32] = ins(j < 7, 3'h0, 3'h7, 4'h0, 1'b0);
            run_start(4'h0, 4'h0);
            wr_en = 8'h11;
            wr_reg = 32'h00030000;
            wr_data[31:0] = 32'h00000100;
            wr_data[159:128] = 32'h5A5A0002;
            @(negedge sys_clk_in);
            wr_en = 8'h00;
            lim = 4'h1;
            wait_for(2);
            check_mask(seen[0], 8'h8A);
            check_word(n_x, 32'h1);
            check_mask({4'h0, last_mreq}, 8'h0B);
            check_mask({4'h0, last_msize}, 8'h0A);
            check_word(last_maddr[31:0], 32'h0000010C);
            check_word(last_maddr[63:32], 32'h00000000);
            check_word(last_mwdata[95:64], 32'h5A5A0002);
            check_word({18'h0, last_mtag}, 32'h000029D5);
        end
    endtask
    task report_and_stop;
        begin
            if (failures == 0 && checks_done > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    initial begin
        repeat (5) @(negedge sys_clk_in);
        rst_in = 1'b0;
        t_full;
        t_slow;
        t_drop;
        t_regs;
        t_mem;
        report_and_stop;
    end
endmodule

/* verification/vpd_prog_mem.sv */
`timescale 1ns/10ps
// ************************************************
// Program memory model
// ************************************************
module vpd_prog_mem (
    input wire clk_in,
    input wire rst_in,
    input wire req_in,
    input wire [31:0] addr_in,
    input wire [3:0] lag_in,
    input wire [3:0] limit_in,
    output reg valid_out,
    output reg [255:0] data_out
);
    reg [255:0] prog [0:3];
    reg [3:0] wait_q;
    reg [3:0] served_q;
    // whole packets only; idle data inverted so stale words never match
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wait_q <= 4'h0;
            served_q <= 4'h0;
            valid_out <= 1'b0;
            data_out <= 256'h0;
        end else if (valid_out) begin
            valid_out <= 1'b0;
            data_out <= ~data_out;
            served_q <= served_q + 4'h1;
        end else if (req_in && served_q < limit_in) begin
            if (wait_q >= lag_in) begin
                valid_out <= 1'b1;
                data_out <= prog[addr_in[6:5]];
                wait_q <= 4'h0;
            end else begin
                wait_q <= wait_q + 4'h1;
            end
        end
    end
endmodule
